//--- src/htp_top.sv
// Functional notes
// - Input code scales linearly; full scale is 100 percent.
// - Input mode drives until standby or mode change.
// - Fixed-frequency bit selects seven-bit period, else tracking.
// - Continuous modes start on entry, stop on exit.
// - External trigger modes: pin controls fire request.
// - Serial mode: host sets fire, clearing it cancels.
// - Edge mode: rising edge sets fire, starts playback.
// - Rising edge while fire high cancels and clears.
// - Edge mode ignores falling edges.
// - Level mode: fire follows pin; falling edge cancels.
// - Noise gate suppresses input below selected threshold.
// - Supply level register updates during playback.
// - Stored image restores configuration registers after reset.
// - Standby keeps every register except fire, which it clears; wakes quickly.
// - Watchdog idles stalled serial-bus protocol after timeout.
// - Watchdog inactive during standby.
// - Over-temperature stops drive and sets thermal flag.
// - Output short latches flag, stops, restarts when gone.
// - Regulator short holds device in default state.
// - Brownout issues internal reset to default state.
// - Three-bit mode field selects the interface.
// - Internal mode: fire stays high until sequence done.
`timescale 1ns/1ps
`default_nettype none

module htp_top
	import htp_pkg::*;
#(
	parameter int unsigned WDOG_LIMIT = WDOG_CYCLES
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Register port from the serial-bus protocol engine
	input  wire htp_reg_req_t        reg_req_i,
	output logic       [7:0]         reg_rdata_o,
	// Protocol engine supervision
	input  wire logic                bus_busy_i,
	input  wire logic                bus_activity_i,
	output logic                     bus_reset_o,
	// Input and trigger pin, digitised input samples
	input  wire logic                input_trigger_pin_i,
	input  wire logic  [7:0]         input_code_i,
	input  wire logic  [7:0]         duty_code_i,
	input  wire logic  [7:0]         supply_code_i,
	// Protection comparators
	input  wire htp_prot_t           prot_i,
	// Configuration store
	input  wire logic                otp_programmed_i,
	input  wire logic  [CFG_BITS-1:0] otp_image_i,
	output logic       [CFG_BITS-1:0] cfg_o,
	// Sequencer handshake
	input  wire logic                seq_done_i,
	output logic                     go_o,
	output logic                     play_start_o,
	output logic                     play_cancel_o,
	// Drive control
	output logic                     drive_en_o,
	output logic       [7:0]         drive_level_o,
	output logic                     fixed_frequency_select_o,
	output logic       [6:0]         fixed_period_o,
	output logic                     standby_o
);

	htp_state_t s_q;
	htp_state_t s_d;

	htp_prot_t prot;
	logic      trig;

	htp_sync #(
		.WIDTH(5)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i({prot_i, input_trigger_pin_i}),
		.level_o({prot, trig})
	);

	htp_wdog #(
		.LIMIT(WDOG_LIMIT)
	) u_wdog (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.busy_i     (bus_busy_i),
		.activity_i (bus_activity_i),
		.standby_i  (s_q.mode[MODE_STANDBY_BIT]),
		.bus_reset_o(bus_reset_o)
	);

	logic       soft_rst;
	logic       standby;
	logic [2:0] mode;
	logic       trig_mode;
	logic       cont;
	logic       shut;
	logic       rise;
	logic       fire_wr;
	logic       fire_n;
	logic [7:0] in_code;
	logic [7:0] rd_val;
	int         idx;

	always_comb begin
		s_d        = s_q;
		s_d.start  = 1'b0;
		s_d.cancel = 1'b0;
		idx        = 0;
		rd_val     = 8'h00;
		fire_n     = s_q.fire;
		in_code    = 8'h00;
		standby    = s_q.mode[MODE_STANDBY_BIT];
		mode       = s_q.mode[2:0];
		trig_mode  = (mode == MODE_INT) || (mode == MODE_EDGE) || (mode == MODE_LEVEL);
		rise       = trig && !s_q.trig_prev;
		fire_wr    = reg_req_i.wr && (reg_req_i.addr == ADDR_FIRE);
		soft_rst   = prot.brownout || prot.reg_short || s_q.dev_rst;
		shut       = 1'b0;
		cont       = 1'b0;

		if (soft_rst) begin
			s_d = ST_RST;
		end else if (s_q.restore) begin
			s_d.restore = 1'b0;
			if (otp_programmed_i) begin
				s_d.cfg = otp_image_i;
			end
		end else begin
			// Register writes; standby changes none of the stored values except the fire bit, cleared below.
			if (reg_req_i.wr) begin
				if (htp_cfg_hit(reg_req_i.addr)) begin
					idx = int'(reg_req_i.addr - ADDR_CFG_LO);
					s_d.cfg[idx*8 +: 8] = reg_req_i.wdata;
				end
				case (reg_req_i.addr)
					ADDR_MODE: begin
						s_d.mode    = {1'b0, reg_req_i.wdata[6:0]};
						s_d.dev_rst = reg_req_i.wdata[MODE_RESET_BIT];
					end
					ADDR_AMP:    s_d.amp    = reg_req_i.wdata;
					ADDR_LOOP:   s_d.loop   = reg_req_i.wdata;
					ADDR_PERIOD: s_d.period = reg_req_i.wdata;
					default: begin
					end
				endcase
			end

			// Protection flags: the set wins over the release.
			s_d.therm = prot.thermal;
			if (prot.out_short && (s_q.go || s_q.drive_en)) begin
				s_d.oshort = 1'b1;
			end else if (!prot.out_short) begin
				s_d.oshort = 1'b0;
			end
			shut = prot.thermal || s_q.oshort;

			// Fire request bit.
			s_d.trig_prev = trig;
			if (seq_done_i && (mode != MODE_LEVEL)) begin
				fire_n = 1'b0;
			end
			if (fire_wr) begin
				fire_n = reg_req_i.wdata[FIRE_BIT];
			end
			if ((mode == MODE_EDGE) && rise) begin
				fire_n = !fire_n;
			end
			if (mode == MODE_LEVEL) begin
				fire_n = trig;
			end
			if (!trig_mode || standby || shut) begin
				fire_n = 1'b0;
			end
			s_d.fire   = fire_n;
			s_d.start  = !s_q.fire && fire_n;
			s_d.cancel = s_q.fire && !fire_n && !seq_done_i;

			// Continuous modes run while the mode stays selected and neither standby nor a thermal or short shutdown is active.
			cont         = htp_is_cont(mode) && !standby && !shut;
			s_d.go       = fire_n || cont;
			s_d.drive_en = cont;

			in_code = s_q.loop[LOOP_ANALOG_BIT] ? input_code_i : duty_code_i;
			if (mode == MODE_AUDIO) begin
				in_code = input_code_i;
			end
			if (in_code < htp_gate_level(s_q.loop[LOOP_GATE_LSB +: 2])) begin
				in_code = 8'h00;
			end
			if (!cont) begin
				s_d.level = 8'h00;
			end else if (mode == MODE_AMP) begin
				s_d.level = s_q.amp;
			end else begin
				s_d.level = in_code;
			end

			if (s_q.go) begin
				s_d.supply = supply_code_i;
			end

			// Read data.
			if (reg_req_i.rd) begin
				if (htp_cfg_hit(reg_req_i.addr)) begin
					idx    = int'(reg_req_i.addr - ADDR_CFG_LO);
					rd_val = s_q.cfg[idx*8 +: 8];
				end
				case (reg_req_i.addr)
					ADDR_STATUS: begin
						rd_val[STS_SHORT_BIT] = s_q.oshort;
						rd_val[STS_THERM_BIT] = s_q.therm;
					end
					ADDR_MODE:   rd_val = s_q.mode;
					ADDR_AMP:    rd_val = s_q.amp;
					ADDR_FIRE:   rd_val[FIRE_BIT] = s_q.fire;
					ADDR_LOOP:   rd_val = s_q.loop;
					ADDR_PERIOD: rd_val = {1'b0, s_q.period[6:0]};
					ADDR_SUPPLY: rd_val = s_q.supply;
					default: begin
					end
				endcase
				s_d.rdata = rd_val;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o              = s_q.rdata;
	assign cfg_o                    = s_q.cfg;
	assign go_o                     = s_q.go;
	assign play_start_o             = s_q.start;
	assign play_cancel_o            = s_q.cancel;
	assign drive_en_o               = s_q.drive_en;
	assign drive_level_o            = s_q.level;
	assign fixed_frequency_select_o = s_q.loop[LOOP_FIXED_BIT];
	assign fixed_period_o           = s_q.period[6:0];
	assign standby_o                = s_q.mode[MODE_STANDBY_BIT];

endmodule : htp_top

`default_nettype wire

//--- shared/htp_pkg.sv
`default_nettype none

package htp_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MODE   = 8'h01;
	localparam logic [7:0] ADDR_AMP    = 8'h02;
	localparam logic [7:0] ADDR_FIRE   = 8'h0c;
	localparam logic [7:0] ADDR_CFG_LO = 8'h16;
	localparam logic [7:0] ADDR_CFG_HI = 8'h1a;
	localparam logic [7:0] ADDR_LOOP   = 8'h1d;
	localparam logic [7:0] ADDR_PERIOD = 8'h20;
	localparam logic [7:0] ADDR_SUPPLY = 8'h21;

	localparam int CFG_WORDS = 5;
	localparam int CFG_BITS  = CFG_WORDS * 8;

	// Field positions.
	localparam int STS_SHORT_BIT    = 0;
	localparam int STS_THERM_BIT    = 1;
	localparam int MODE_STANDBY_BIT = 6;
	localparam int MODE_RESET_BIT   = 7;
	localparam int FIRE_BIT         = 0;
	localparam int LOOP_FIXED_BIT   = 0;
	localparam int LOOP_ANALOG_BIT  = 1;
	localparam int LOOP_GATE_LSB    = 2;

	// Interface mode codes in the low three bits of the mode register.
	localparam logic [2:0] MODE_INT   = 3'h0;
	localparam logic [2:0] MODE_EDGE  = 3'h1;
	localparam logic [2:0] MODE_LEVEL = 3'h2;
	localparam logic [2:0] MODE_INPUT = 3'h3;
	localparam logic [2:0] MODE_AUDIO = 3'h4;
	localparam logic [2:0] MODE_AMP   = 3'h5;

	// Reset values.
	localparam logic [7:0] MODE_RST   = 8'h40;
	localparam logic [7:0] AMP_RST    = 8'h00;
	localparam logic [7:0] LOOP_RST   = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'h33;

	// Noise gate thresholds on the 8-bit input scale, where 8'hff is full scale.
	localparam logic [7:0] GATE_LVL1 = 8'h05;
	localparam logic [7:0] GATE_LVL2 = 8'h0a;
	localparam logic [7:0] GATE_LVL3 = 8'h14;

	// Serial-bus watchdog timeout.
	localparam int unsigned CLK_KHZ      = 40000;
	localparam int unsigned WDOG_TIME_US = 4330;
	localparam int unsigned WDOG_CYCLES  = (WDOG_TIME_US * CLK_KHZ) / 1000;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} htp_reg_req_t;

	typedef struct packed {
		logic thermal;
		logic out_short;
		logic reg_short;
		logic brownout;
	} htp_prot_t;

	typedef struct packed {
		logic [7:0]          mode;
		logic [7:0]          amp;
		logic                fire;
		logic [7:0]          loop;
		logic [7:0]          period;
		logic [7:0]          supply;
		logic [CFG_BITS-1:0] cfg;
		logic                therm;
		logic                oshort;
		logic                trig_prev;
		logic                restore;
		logic                dev_rst;
		logic                go;
		logic                start;
		logic                cancel;
		logic                drive_en;
		logic [7:0]          level;
		logic [7:0]          rdata;
	} htp_state_t;

	localparam htp_state_t ST_RST = '{
		mode:    MODE_RST,
		amp:     AMP_RST,
		loop:    LOOP_RST,
		period:  PERIOD_RST,
		restore: 1'b1,
		default: '0
	};

	function automatic logic htp_cfg_hit(input logic [7:0] addr);
		htp_cfg_hit = (addr >= ADDR_CFG_LO) && (addr <= ADDR_CFG_HI);
	endfunction : htp_cfg_hit

	function automatic logic htp_is_cont(input logic [2:0] mode);
		htp_is_cont = (mode == MODE_INPUT) || (mode == MODE_AUDIO) || (mode == MODE_AMP);
	endfunction : htp_is_cont

	function automatic logic [7:0] htp_gate_level(input logic [1:0] sel);
		case (sel)
			2'h1:    htp_gate_level = GATE_LVL1;
			2'h2:    htp_gate_level = GATE_LVL2;
			2'h3:    htp_gate_level = GATE_LVL3;
			default: htp_gate_level = 8'h00;
		endcase
	endfunction : htp_gate_level

endpackage : htp_pkg

`default_nettype wire

//--- src/htp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module htp_sync
	import htp_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Asynchronous levels in, filtered levels out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] level_o
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} htp_sync_state_t;

	htp_sync_state_t s_q;
	htp_sync_state_t s_d;

	// The output takes a new value only once the second and third stages agree.
	always_comb begin
		s_d       = s_q;
		s_d.s1    = async_i;
		s_d.s2    = s_q.s1;
		s_d.s3    = s_q.s2;
		s_d.level = (~(s_q.s2 ^ s_q.s3) & s_q.s2) | ((s_q.s2 ^ s_q.s3) & s_q.level);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.level;

endmodule : htp_sync

`default_nettype wire

//--- src/htp_wdog.sv
`timescale 1ns/1ps
`default_nettype none

module htp_wdog
	import htp_pkg::*;
#(
	parameter int unsigned LIMIT = WDOG_CYCLES,
	parameter int unsigned CW    = $clog2(LIMIT + 1)
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Protocol engine state
	input  wire logic busy_i,
	input  wire logic activity_i,
	input  wire logic standby_i,
	// Return-to-idle pulse
	output logic      bus_reset_o
);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          pulse;
	} htp_wdog_state_t;

	htp_wdog_state_t s_q;
	htp_wdog_state_t s_d;

	always_comb begin
		s_d       = s_q;
		s_d.pulse = 1'b0;
		if (standby_i || !busy_i || activity_i) begin
			s_d.cnt = '0;
		end else if (s_q.cnt == CW'(LIMIT - 1)) begin
			s_d.cnt   = '0;
			s_d.pulse = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_reset_o = s_q.pulse;

endmodule : htp_wdog

`default_nettype wire

//--- test/htp_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module htp_monitor
	import htp_pkg::*;
#(
	parameter int unsigned WDOG_LIMIT = WDOG_CYCLES
) (
	// Clock, reset and register port
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire htp_reg_req_t        reg_req_i,
	input wire logic [7:0]          reg_rdata_o,
	// Bus supervision and inputs
	input wire logic                bus_busy_i,
	input wire logic                bus_activity_i,
	input wire logic                bus_reset_o,
	input wire logic                input_trigger_pin_i,
	input wire logic [7:0]          input_code_i,
	input wire logic [7:0]          duty_code_i,
	input wire logic [7:0]          supply_code_i,
	input wire htp_prot_t           prot_i,
	input wire logic                otp_programmed_i,
	input wire logic [CFG_BITS-1:0] otp_image_i,
	input wire logic [CFG_BITS-1:0] cfg_o,
	// Playback and drive
	input wire logic                seq_done_i,
	input wire logic                go_o,
	input wire logic                play_start_o,
	input wire logic                play_cancel_o,
	input wire logic                drive_en_o,
	input wire logic [7:0]          drive_level_o,
	input wire logic                fixed_frequency_select_o,
	input wire logic [6:0]          fixed_period_o,
	input wire logic                standby_o
);
	int unsigned stall_q;

	always_ff @(posedge clk_i) begin
		if (rst_i || bus_reset_o || !(bus_busy_i && !bus_activity_i && !standby_o))
			stall_q <= 0;
		else
			stall_q <= stall_q + 1;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_fault_held;
		(prot_i.brownout || prot_i.reg_short) [*8];
	endsequence
	sequence s_heat_held;
		prot_i.thermal [*8];
	endsequence

	a_fault_default: assert property (s_fault_held |-> standby_o && !go_o && !drive_en_o)
		else $error("fault left the device active");
	a_heat_stop: assert property (s_heat_held |-> !drive_en_o && !play_start_o)
		else $error("drive kept running while hot");
	a_start_go: assert property (play_start_o |-> go_o)
		else $error("start without go");
	a_start_pulse: assert property (play_start_o |=> !play_start_o)
		else $error("start pulse too long");
	a_cancel_alone: assert property (play_cancel_o |-> !play_start_o)
		else $error("cancel and start together");
	a_standby_idle: assert property (standby_o && $past(standby_o) |-> !drive_en_o)
		else $error("drive on in standby");
	a_level_zero: assert property (!drive_en_o |-> drive_level_o == 8'h00)
		else $error("drive level without drive");
	a_wdog_sleep: assert property (bus_reset_o |-> $past(bus_busy_i && !standby_o))
		else $error("bus reset without active stall");
	a_wdog_early: assert property (bus_reset_o |-> stall_q + 1 >= WDOG_LIMIT)
		else $error("bus reset too early");
	a_wdog_late: assert property (stall_q <= WDOG_LIMIT + 3)
		else $error("bus reset missing");
	a_cfg_restore: assert property ($fell(rst_i) && otp_programmed_i |-> ##[1:3] cfg_o == otp_image_i)
		else $error("stored image not restored");
endmodule : htp_monitor

bind htp_top htp_monitor #(.WDOG_LIMIT(WDOG_LIMIT)) i_htp_monitor (.*);

`default_nettype wire

//--- test/htp_host.sv
`timescale 1ns/1ps
`default_nettype none

module htp_host (
	// Clock and trigger pin
	input  wire logic clk_i,
	output logic      pin_o
);
	initial pin_o = 1'b0;

	// Each level is held for n cycles; pulses are given at least 40 cycles high.
	task automatic set(input logic v, input int n);
		@(posedge clk_i) #1 pin_o = v;
		repeat (n) @(posedge clk_i);
		#1;
	endtask : set
endmodule : htp_host

`default_nettype wire

//--- test/htp_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module htp_top_test;
	import htp_pkg::*;
	localparam int unsigned LIM = 50;
	logic                clk_i;
	logic                rst_i = 1'b1;
	htp_reg_req_t        reg_req_i = '0;
	logic                bus_busy_i = 1'b0;
	logic                bus_activity_i = 1'b0;
	wire logic           input_trigger_pin_i;
	logic [7:0]          input_code_i = 8'h00;
	logic [7:0]          duty_code_i = 8'h40;
	logic [7:0]          supply_code_i = 8'h9a;
	htp_prot_t           prot_i = '0;
	logic                otp_programmed_i = 1'b1;
	logic [CFG_BITS-1:0] otp_image_i = 40'h1122334455;
	logic                seq_done_i = 1'b0;
	logic [7:0]          reg_rdata_o;
	logic [7:0]          drive_level_o;
	logic [6:0]          fixed_period_o;
	logic [CFG_BITS-1:0] cfg_o;
	logic                bus_reset_o;
	logic                go_o;
	logic                play_start_o;
	logic                play_cancel_o;
	logic                drive_en_o;
	logic                fixed_frequency_select_o;
	logic                standby_o;
	int                  mismatches = 0;
	int                  check_count = 0;
	int                  k;
	logic [7:0]          cin [3] = '{8'h13, 8'h14, 8'h80};
	logic [7:0]          cout [3] = '{8'h00, 8'h14, 8'h80};

	htp_top #(.WDOG_LIMIT(LIM)) i_htp_top (.*);
	htp_host i_htp_host (.clk_i(clk_i), .pin_o(input_trigger_pin_i));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL %0t got %h want %h", $time, s, e);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i) #1 reg_req_i = '{1'b1, 1'b0, a, d};
		@(posedge clk_i) #1 reg_req_i = '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i) #1 reg_req_i = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_i) #1 reg_req_i = '0;
		tick(1);
		chk(reg_rdata_o, e);
	endtask : rd

	task automatic stall(input int n, output int c);
		c = 0;
		bus_busy_i = 1'b1;
		repeat (n) begin
			tick(1);
			if (bus_reset_o === 1'b1)
				c++;
		end
		bus_busy_i = 1'b0;
	endtask : stall

	initial begin
		tick(5000);
		mismatches++;
		complete_run();
	end

	initial begin
		tick(5);
		rst_i = 1'b0;
		tick(2);
		rd(ADDR_MODE, MODE_RST);
		rd(ADDR_LOOP, LOOP_RST);
		rd(ADDR_PERIOD, PERIOD_RST);
		rd(ADDR_STATUS, 8'h00);
		rd(8'h30, 8'h00);
		chk(8'(standby_o), 8'h01);
		$display("test reset done");
		wr(ADDR_MODE, 8'h00);
		chk(8'(standby_o), 8'h00);
		wr(ADDR_FIRE, 8'h01);
		chk(8'(go_o), 8'h01);
		chk(8'(play_start_o), 8'h01);
		rd(ADDR_FIRE, 8'h01);
		@(posedge clk_i) #1 seq_done_i = 1'b1;
		@(posedge clk_i) #1 seq_done_i = 1'b0;
		tick(1);
		chk(8'(go_o), 8'h00);
		wr(ADDR_FIRE, 8'h01);
		wr(ADDR_FIRE, 8'h00);
		chk(8'(play_cancel_o), 8'h01);
		chk(8'(go_o), 8'h00);
		$display("test serial done");
		wr(ADDR_MODE, 8'h01);
		i_htp_host.set(1'b1, 40);
		chk(8'(go_o), 8'h01);
		i_htp_host.set(1'b0, 40);
		chk(8'(go_o), 8'h01);
		i_htp_host.set(1'b1, 40);
		chk(8'(go_o), 8'h00);
		i_htp_host.set(1'b0, 8);
		wr(ADDR_MODE, 8'h02);
		i_htp_host.set(1'b1, 40);
		rd(ADDR_FIRE, 8'h01);
		i_htp_host.set(1'b0, 8);
		chk(8'(go_o), 8'h00);
		$display("test trigger done");
		wr(ADDR_AMP, 8'h80);
		wr(ADDR_MODE, 8'h05);
		tick(8);
		chk(8'(drive_en_o), 8'h01);
		chk(drive_level_o, 8'h80);
		rd(ADDR_SUPPLY, 8'h9a);
		prot_i.thermal = 1'b1;
		tick(8);
		chk(8'(drive_en_o), 8'h00);
		rd(ADDR_STATUS, 8'h02);
		prot_i.thermal = 1'b0;
		tick(8);
		prot_i.out_short = 1'b1;
		tick(8);
		rd(ADDR_STATUS, 8'h01);
		prot_i.out_short = 1'b0;
		tick(8);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_MODE, 8'h45);
		tick(2);
		chk(8'(drive_en_o), 8'h00);
		rd(ADDR_AMP, 8'h80);
		stall(LIM + 10, k);
		chk(8'(k), 8'h00);
		$display("test amplitude done");
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_MODE, 8'(m));
			rd(ADDR_MODE, 8'(m));
		end
		wr(ADDR_LOOP, 8'h0f);
		wr(ADDR_PERIOD, 8'h85);
		wr(ADDR_MODE, 8'h03);
		tick(2);
		chk(8'(fixed_frequency_select_o), 8'h01);
		chk({1'b0, fixed_period_o}, 8'h05);
		rd(ADDR_PERIOD, 8'h05);
		for (int i = 0; i < 3; i++) begin
			input_code_i = cin[i];
			tick(4);
			chk(drive_level_o, cout[i]);
		end
		chk(8'(drive_en_o), 8'h01);
		wr(ADDR_MODE, 8'h00);
		stall(LIM + 10, k);
		chk(8'(k), 8'h01);
		$display("test input done");
		wr(ADDR_CFG_LO, 8'h5a);
		rd(ADDR_CFG_LO, 8'h5a);
		prot_i.brownout = 1'b1;
		tick(8);
		prot_i.brownout = 1'b0;
		tick(8);
		rd(ADDR_MODE, MODE_RST);
		rd(ADDR_CFG_LO, otp_image_i[7:0]);
		chk(cfg_o[7:0], otp_image_i[7:0]);
		$display("test brownout done");
		wr(ADDR_MODE, 8'h05);
		prot_i.reg_short = 1'b1;
		tick(8);
		chk(8'(standby_o), 8'h01);
		chk(8'(drive_en_o), 8'h00);
		prot_i.reg_short = 1'b0;
		tick(8);
		rd(ADDR_MODE, MODE_RST);
		wr(ADDR_MODE, 8'h05);
		wr(ADDR_MODE, 8'h80);
		tick(3);
		rd(ADDR_MODE, MODE_RST);
		chk(8'(drive_en_o), 8'h00);
		$display("test supply faults done");
		complete_run();
	end
endmodule : htp_top_test

`default_nettype wire
